// ---- rtl/ncpm_pkg.sv ----
// Shared constants, types and register map of the network port manager
// Assumes one 10 MHz clock domain and an AXI4-Lite master for software access
package ncpm_pkg;

    // ----------------------------------------
    // Ports and bus
    // ----------------------------------------
    localparam int NCPM_PORTS = 8;
    localparam int NCPM_PW = 3;
    localparam int NCPM_AW = 8;
    localparam logic [3:0] NCPM_PORT_AUTO = 4'hf;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] NCPM_REG_CTRL = 8'h00;
    localparam logic [7:0] NCPM_REG_OPER = 8'h04;
    localparam logic [7:0] NCPM_REG_CMD = 8'h08;
    localparam logic [7:0] NCPM_REG_FLAGS = 8'h0c;
    localparam logic [7:0] NCPM_REG_USED = 8'h10;
    localparam logic [7:0] NCPM_REG_CODE0 = 8'h20;
    localparam logic [7:0] NCPM_REG_DATA0 = 8'h40;
    localparam logic [7:0] NCPM_REG_TOP = 8'h60;
    localparam logic [31:0] NCPM_CTRL_RST = 32'h0000_0000;

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int NCPM_CTRL_KIND_LSB = 0;
    localparam int NCPM_CTRL_PORT_LSB = 4;
    localparam int NCPM_CTRL_EDGE_BIT = 8;
    localparam int NCPM_CTRL_COND_BIT = 9;

    // ----------------------------------------
    // Command and service codes
    // ----------------------------------------
    localparam logic [15:0] NCPM_CMD_EXPLICIT = 16'h2801;
    localparam logic [15:0] NCPM_CMD_DATA_WRITE = 16'h0102;
    localparam logic [15:0] NCPM_CMD_DATA_READ = 16'h0101;
    localparam logic [7:0] NCPM_SVC_GET_ATTR = 8'h0e;
    localparam logic [7:0] NCPM_SVC_SET_ATTR = 8'h10;
    localparam logic [7:0] NCPM_SVC_WORD_READ = 8'h1e;
    localparam logic [7:0] NCPM_SVC_WORD_WRITE = 8'h1f;
    localparam logic [15:0] NCPM_CODE_OK = 16'h0000;
    localparam logic [1:0] NCPM_LAST_BEAT = 2'h3;
    localparam logic [1:0] NCPM_RESP_OKAY = 2'b00;
    localparam logic [1:0] NCPM_RESP_DECERR = 2'b11;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        NCPM_K_SEND = 3'b000,
        NCPM_K_RECV = 3'b001,
        NCPM_K_CMND = 3'b010,
        NCPM_K_EXPL = 3'b011,
        NCPM_K_GATR = 3'b100,
        NCPM_K_SATR = 3'b101,
        NCPM_K_WRD = 3'b110,
        NCPM_K_WWR = 3'b111
    } ncpm_kind_t;

    typedef struct packed {
        ncpm_kind_t kind;
        logic expl;
        logic [15:0] cmd;
        logic [7:0] svc;
        logic [7:0] cnt;
        logic [15:0] src;
        logic [15:0] dst;
    } ncpm_req_t;

    typedef struct packed {
        logic [2:0] port;
        logic [1:0] idx;
        logic last;
        logic [15:0] word;
    } ncpm_beat_t;

    typedef struct packed {
        logic [2:0] port;
        logic net_err;
        logic expl_err;
        logic [15:0] code;
        logic [15:0] data;
    } ncpm_resp_t;

endpackage : ncpm_pkg

// ---- rtl/ncpm_port_manager.sv ----
// Eight-port network request manager with AXI4-Lite register access
// Assumes scan_tick, srv_slot and the network side share aclk
`timescale 1ns/1ps

module ncpm_port_manager (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [ncpm_pkg::NCPM_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ncpm_pkg::NCPM_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Scan timing
    input wire logic scan_tick,
    input wire logic srv_slot,
    // Network frame out
    output logic net_tx_valid,
    input wire logic net_tx_ready,
    output ncpm_pkg::ncpm_beat_t net_tx_beat,
    // Network response in
    input wire logic net_rx_valid,
    input wire ncpm_pkg::ncpm_resp_t net_rx_resp
);
    import ncpm_pkg::*;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : byte_merge

    function automatic ncpm_req_t build_req(input logic [31:0] ctrl, input logic [31:0] oper,
                                            input logic [31:0] cmdw);
        ncpm_req_t r;
        r.kind = ncpm_kind_t'(ctrl[NCPM_CTRL_KIND_LSB +: 3]);
        r.src = oper[15:0];
        r.dst = oper[31:16];
        r.cnt = cmdw[31:24];
        r.svc = cmdw[23:16];
        r.cmd = NCPM_CMD_EXPLICIT;
        r.expl = 1'b1;
        case (r.kind)
            NCPM_K_SEND: begin
                r.cmd = NCPM_CMD_DATA_WRITE;
                r.expl = 1'b0;
            end
            NCPM_K_RECV: begin
                r.cmd = NCPM_CMD_DATA_READ;
                r.expl = 1'b0;
            end
            NCPM_K_CMND: begin
                r.cmd = cmdw[15:0];
                r.expl = (cmdw[15:0] == NCPM_CMD_EXPLICIT);
            end
            NCPM_K_GATR: r.svc = NCPM_SVC_GET_ATTR;
            NCPM_K_SATR: r.svc = NCPM_SVC_SET_ATTR;
            NCPM_K_WRD: r.svc = NCPM_SVC_WORD_READ;
            NCPM_K_WWR: r.svc = NCPM_SVC_WORD_WRITE;
            default: ;
        endcase
        return r;
    endfunction : build_req

    function automatic logic [15:0] beat_word(input ncpm_req_t r, input logic [1:0] idx);
        logic [15:0] w;
        case (idx)
            2'h0: w = r.cmd;
            2'h1: w = {r.svc, r.cnt};
            2'h2: w = r.src;
            default: w = r.dst;
        endcase
        return w;
    endfunction : beat_word

    function automatic logic [3:0] lowest_set(input logic [NCPM_PORTS-1:0] v);
        logic [3:0] r;
        r = NCPM_PORT_AUTO;
        for (int i = NCPM_PORTS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : lowest_set

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic aw_have_ff, w_have_ff, bvalid_ff, rvalid_ff, cond_prev_ff, tx_busy_ff;
    logic [NCPM_AW-1:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff, ctrl_ff, oper_ff, cmd_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff, tx_idx_ff;
    logic [NCPM_PORTS-1:0] avail_ff, err_ff, expl_err_ff, done_ff, done_pend_ff, tx_pend_ff;
    logic [NCPM_PW-1:0] used_port_ff, tx_port_ff;
    ncpm_req_t req_ff [NCPM_PORTS];
    logic [15:0] code_ff [NCPM_PORTS];
    logic [15:0] data_ff [NCPM_PORTS];
    logic [15:0] tx_word_ff;

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    logic wr_fire, wr_hit, rd_hit, tx_fire;
    logic [31:0] rd_val;
    logic [3:0] tx_pick;

    assign s_axi_awready = !aw_have_ff && !bvalid_ff;
    assign s_axi_wready = !w_have_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
    assign wr_hit = (awaddr_ff == NCPM_REG_CTRL) || (awaddr_ff == NCPM_REG_OPER) ||
                    (awaddr_ff == NCPM_REG_CMD);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= NCPM_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? NCPM_RESP_OKAY : NCPM_RESP_DECERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= NCPM_CTRL_RST;
            oper_ff <= '0;
            cmd_ff <= '0;
        end else if (wr_fire) begin
            if (awaddr_ff == NCPM_REG_CTRL) begin
                ctrl_ff <= byte_merge(ctrl_ff, wdata_ff, wstrb_ff);
            end
            if (awaddr_ff == NCPM_REG_OPER) begin
                oper_ff <= byte_merge(oper_ff, wdata_ff, wstrb_ff);
            end
            if (awaddr_ff == NCPM_REG_CMD) begin
                cmd_ff <= byte_merge(cmd_ff, wdata_ff, wstrb_ff);
            end
        end
    end

    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            NCPM_REG_CTRL: rd_val = ctrl_ff;
            NCPM_REG_OPER: rd_val = oper_ff;
            NCPM_REG_CMD: rd_val = cmd_ff;
            NCPM_REG_FLAGS: rd_val = {done_ff, expl_err_ff, err_ff, avail_ff};
            NCPM_REG_USED: rd_val = {|avail_ff, 28'h0, used_port_ff};
            default: begin
                rd_hit = 1'b0;
                if (s_axi_araddr >= NCPM_REG_CODE0 && s_axi_araddr < NCPM_REG_TOP &&
                    s_axi_araddr[1:0] == 2'b00) begin
                    rd_hit = 1'b1;
                    if (s_axi_araddr < NCPM_REG_DATA0) begin
                        rd_val = {16'h0, code_ff[s_axi_araddr[4:2]]};
                    end else begin
                        rd_val = {16'h0, data_ff[s_axi_araddr[4:2]]};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= NCPM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_val;
            rresp_ff <= rd_hit ? NCPM_RESP_OKAY : NCPM_RESP_DECERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Request start at scan tick
    // ----------------------------------------
    logic cond_now, trig, start_ok;
    logic [3:0] sel_raw, start_port;
    logic [NCPM_PORTS-1:0] start_vec, resp_vec;
    ncpm_req_t new_req;

    assign cond_now = ctrl_ff[NCPM_CTRL_COND_BIT];
    assign trig = scan_tick && cond_now && (!ctrl_ff[NCPM_CTRL_EDGE_BIT] || !cond_prev_ff);
    assign sel_raw = ctrl_ff[NCPM_CTRL_PORT_LSB +: 4];
    assign start_port = (sel_raw == NCPM_PORT_AUTO) ? lowest_set(avail_ff) : sel_raw;
    assign start_ok = trig && !start_port[3] && avail_ff[start_port[NCPM_PW-1:0]];
    assign new_req = build_req(ctrl_ff, oper_ff, cmd_ff);
    assign resp_vec = net_rx_valid ? (NCPM_PORTS'(1) << net_rx_resp.port) : '0;

    always_comb begin
        start_vec = '0;
        if (start_ok) begin
            start_vec[start_port[NCPM_PW-1:0]] = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cond_prev_ff <= 1'b0;
            used_port_ff <= '0;
        end else begin
            if (scan_tick) begin
                cond_prev_ff <= cond_now;
            end
            if (start_ok) begin
                used_port_ff <= start_port[NCPM_PW-1:0];
            end
        end
    end

    // ----------------------------------------
    // Per-port flags, codes and data
    // ----------------------------------------
        for (genvar gp = 0; gp < NCPM_PORTS; gp++) begin : g_port
            logic hit;
            assign hit = resp_vec[gp] && !avail_ff[gp] && !tx_pend_ff[gp];

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    avail_ff[gp] <= 1'b1;
                    err_ff[gp] <= 1'b0;
                    expl_err_ff[gp] <= 1'b0;
                    code_ff[gp] <= NCPM_CODE_OK;
                    data_ff[gp] <= '0;
                    req_ff[gp] <= '0;
                end else if (start_vec[gp]) begin
                    avail_ff[gp] <= 1'b0;
                    err_ff[gp] <= 1'b0;
                    code_ff[gp] <= NCPM_CODE_OK;
                    req_ff[gp] <= new_req;
                end else if (hit) begin
                    avail_ff[gp] <= 1'b1;
                    if (req_ff[gp].kind inside {NCPM_K_RECV, NCPM_K_WRD, NCPM_K_CMND,
                                                NCPM_K_EXPL, NCPM_K_GATR}) begin
                        data_ff[gp] <= net_rx_resp.data;
                    end
                    if (!req_ff[gp].expl) begin
                        err_ff[gp] <= (net_rx_resp.code != NCPM_CODE_OK);
                        code_ff[gp] <= net_rx_resp.code;
                    end else if (net_rx_resp.net_err) begin
                        expl_err_ff[gp] <= 1'b1;
                        err_ff[gp] <= 1'b1;
                        code_ff[gp] <= net_rx_resp.code;
                    end else if (net_rx_resp.expl_err) begin
                        expl_err_ff[gp] <= 1'b1;
                        err_ff[gp] <= 1'b0;
                        code_ff[gp] <= net_rx_resp.code;
                    end else begin
                        expl_err_ff[gp] <= 1'b0;
                        err_ff[gp] <= 1'b0;
                        code_ff[gp] <= NCPM_CODE_OK;
                    end
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    done_pend_ff[gp] <= 1'b0;
                    done_ff[gp] <= 1'b0;
                end else begin
                    done_pend_ff[gp] <= (scan_tick ? 1'b0 : done_pend_ff[gp]) | hit;
                    if (scan_tick) begin
                        done_ff[gp] <= done_pend_ff[gp];
                    end
                end
            end
        end

    // ----------------------------------------
    // Frame transmitter
    // ----------------------------------------
    assign tx_fire = net_tx_valid && net_tx_ready;
    assign tx_pick = lowest_set(tx_pend_ff);
    assign net_tx_valid = tx_busy_ff && srv_slot;
    assign net_tx_beat = {tx_port_ff, tx_idx_ff, tx_idx_ff == NCPM_LAST_BEAT, tx_word_ff};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_pend_ff <= '0;
        end else begin
            tx_pend_ff <= (tx_pend_ff & ~((tx_fire && net_tx_beat.last) ?
                          (NCPM_PORTS'(1) << tx_port_ff) : '0)) | start_vec;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_busy_ff <= 1'b0;
            tx_port_ff <= '0;
            tx_idx_ff <= '0;
            tx_word_ff <= '0;
        end else if (!tx_busy_ff) begin
            if (!tx_pick[3]) begin
                tx_busy_ff <= 1'b1;
                tx_port_ff <= tx_pick[NCPM_PW-1:0];
                tx_idx_ff <= '0;
                tx_word_ff <= beat_word(req_ff[tx_pick[NCPM_PW-1:0]], 2'h0);
            end
        end else if (tx_fire) begin
            if (tx_idx_ff == NCPM_LAST_BEAT) begin
                tx_busy_ff <= 1'b0;
            end else begin
                tx_idx_ff <= tx_idx_ff + 2'h1;
                tx_word_ff <= beat_word(req_ff[tx_port_ff], tx_idx_ff + 2'h1);
            end
        end
    end

endmodule : ncpm_port_manager

// ---- tb/ncpm_far_node.sv ----
// Remote node model: takes frame beats, answers after the last one
// Assumes the manager's clock; stalls every other cycle, holds its answer on request
`timescale 1ns/1ps
module ncpm_far_node (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Scenario control
    input wire logic hold,
    input wire ncpm_pkg::ncpm_resp_t rsp,
    // Frame in and answer out
    input wire logic net_tx_valid,
    output logic net_tx_ready,
    input wire ncpm_pkg::ncpm_beat_t net_tx_beat,
    output logic net_rx_valid,
    output ncpm_pkg::ncpm_resp_t net_rx_resp
);
    import ncpm_pkg::*;
    logic [15:0] words [4];
    logic [31:0] beat_cnt;
    logic [2:0] port_ff;
    logic pend_ff, tgl_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            net_tx_ready <= 1'h0;
            net_rx_valid <= 1'h0;
            net_rx_resp <= '0;
            beat_cnt <= 32'h0;
            pend_ff <= 1'h0;
            tgl_ff <= 1'h0;
        end else begin
            tgl_ff <= ~tgl_ff;
            net_tx_ready <= tgl_ff;
            net_rx_valid <= 1'h0;
            net_rx_resp <= ~net_rx_resp;
            if (net_tx_valid && net_tx_ready) begin
                words[net_tx_beat.idx] <= net_tx_beat.word;
                beat_cnt <= beat_cnt + 32'h1;
                if (net_tx_beat.last) begin
                    pend_ff <= 1'h1;
                    port_ff <= net_tx_beat.port;
                end
            end
            if (pend_ff && !hold) begin
                pend_ff <= 1'h0;
                net_rx_valid <= 1'h1;
                net_rx_resp <= {port_ff, rsp[33:0]};
            end
        end
    end
endmodule : ncpm_far_node

// ---- tb/ncpm_port_manager_props.sv ----
// Checker for the port manager's bus and frame ports
// Assumes one clock domain; bound to every ncpm_port_manager instance
`timescale 1ns/1ps
module ncpm_port_manager_props (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ncpm_pkg::NCPM_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Frame out
    input wire logic srv_slot,
    input wire logic net_tx_valid,
    input wire logic net_tx_ready,
    input wire ncpm_pkg::ncpm_beat_t net_tx_beat
);
    import ncpm_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wait; net_tx_valid && !net_tx_ready; endsequence
    sequence s_move; net_tx_valid && net_tx_ready && !net_tx_beat.last; endsequence
    sequence s_end; net_tx_valid && net_tx_ready && net_tx_beat.last; endsequence
    sequence s_bad_rd; s_axi_arvalid && s_axi_arready && s_axi_araddr >= NCPM_REG_TOP; endsequence
    tx_in_slot_a: assert property (net_tx_valid |-> srv_slot)
        else $error("beat offered outside slot");
    beat_hold_a: assert property (s_wait |=> $stable(net_tx_beat))
        else $error("beat changed before taken");
    beat_step_a: assert property (s_move |=> net_tx_beat.idx == $past(net_tx_beat.idx) + 2'h1
        && net_tx_beat.port == $past(net_tx_beat.port))
        else $error("beat order broken");
    last_mark_a: assert property (net_tx_valid |-> net_tx_beat.last == (net_tx_beat.idx == NCPM_LAST_BEAT))
        else $error("last flag wrong");
    frame_gap_a: assert property (s_end |=> (!net_tx_valid || net_tx_beat.idx == 2'h0))
        else $error("frame restarted mid way");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rd_decerr_a: assert property (s_bad_rd |=> s_axi_rresp == NCPM_RESP_DECERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
endmodule : ncpm_port_manager_props

bind ncpm_port_manager ncpm_port_manager_props u_props (.aclk, .aresetn, .s_axi_awready,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .srv_slot,
    .net_tx_valid, .net_tx_ready, .net_tx_beat);

// ---- tb/ncpm_port_manager_tb.sv ----
// Self-checking bench for the network port manager
// Assumes ncpm_far_node as the remote side; scan ticks and slots come from here
`timescale 1ns/1ps
module ncpm_port_manager_tb;
    import ncpm_pkg::*;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [NCPM_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, scan_tick = 1'h0, srv_slot = 1'h0, hold = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic net_tx_valid, net_tx_ready, net_rx_valid;
    logic [2:0] slot_cnt = 3'h0;
    ncpm_beat_t net_tx_beat;
    ncpm_resp_t net_rx_resp, rsp = '0;
    int err_count = 0, checked = 0, cyc = 0;
    // ----
    // Clock, slots, timeout
    // ----
    always #50 aclk = ~aclk;
    always @(posedge aclk) begin
        slot_cnt <= slot_cnt + 3'h1;
        srv_slot <= (slot_cnt < 3'h3);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    ncpm_port_manager u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scan_tick, .srv_slot, .net_tx_valid,
        .net_tx_ready, .net_tx_beat, .net_rx_valid, .net_rx_resp);
    ncpm_far_node u_far (.aclk, .aresetn, .hold, .rsp, .net_tx_valid, .net_tx_ready,
        .net_tx_beat, .net_rx_valid, .net_rx_resp);
    // ----
    // Shared tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("BAD %0t got %h exp %h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h1;
        @(posedge aclk);
        rr = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h1;
        @(posedge aclk);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : axi_read
    task automatic tick;
        scan_tick <= 1'h1;
        @(posedge aclk);
        scan_tick <= 1'h0;
        @(posedge aclk);
    endtask : tick
    // ----
    // One request from start to done pulse
    // ----
    task automatic do_req(input ncpm_kind_t k, input logic [3:0] pt,
                          input logic [15:0] cmd = '0, code = '0,
                          input logic ne = 1'h0, ee = 1'h0, bz = 1'h0);
        logic [2:0] p;
        logic [15:0] c0;
        logic [7:0] sv;
        logic xp;
        int n;
        c0 = (k == NCPM_K_SEND) ? NCPM_CMD_DATA_WRITE : (k == NCPM_K_RECV) ? NCPM_CMD_DATA_READ
            : (k == NCPM_K_CMND) ? cmd : NCPM_CMD_EXPLICIT;
        sv = (k == NCPM_K_GATR) ? NCPM_SVC_GET_ATTR : (k == NCPM_K_SATR) ? NCPM_SVC_SET_ATTR
            : (k == NCPM_K_WRD) ? NCPM_SVC_WORD_READ : (k == NCPM_K_WWR) ? NCPM_SVC_WORD_WRITE : 8'h33;
        xp = (c0 == NCPM_CMD_EXPLICIT);
        rsp <= '{3'h0, ne, ee, code, ~code};
        hold <= 1'h1;
        axi_write(NCPM_REG_OPER, {16'hd5a0 ^ code, 16'h5e11 ^ code});
        axi_write(NCPM_REG_CMD, {8'h04, 8'h33, cmd});
        axi_write(NCPM_REG_CTRL, {22'h0, 2'h2, pt, 1'h0, k});
        tick();
        axi_write(NCPM_REG_CTRL, {24'h0, pt, 1'h0, k});
        p = (pt == NCPM_PORT_AUTO) ? 3'h0 : pt[2:0];
        axi_read(NCPM_REG_USED);
        chk(32'(rd[2:0]), 32'(p));
        axi_read(NCPM_REG_FLAGS);
        chk(32'(rd[p]), 32'h0);
        chk(32'(rd[8 + p]), 32'h0);
        axi_read(NCPM_REG_CODE0 | {3'h0, p, 2'h0});
        chk(rd, 32'h0);
        repeat (300) if (u_far.pend_ff !== 1'h1) @(posedge aclk);
        chk(32'(u_far.words[0]), 32'(c0));
        chk(32'(u_far.words[2]), 32'(16'h5e11 ^ code));
        chk(32'(u_far.words[3]), 32'(16'hd5a0 ^ code));
        if (xp) chk(32'(u_far.words[1][15:8]), 32'(sv));
        chk(32'(u_far.port_ff), 32'(p));
        if (bz) begin
            n = u_far.beat_cnt;
            axi_write(NCPM_REG_CTRL, {22'h0, 2'h2, pt, 4'h1});
            tick();
            axi_write(NCPM_REG_CTRL, 32'h0);
            repeat (20) @(posedge aclk);
            chk(u_far.beat_cnt, 32'(n));
            axi_read(NCPM_REG_FLAGS);
            chk(32'(rd[p]), 32'h0);
        end
        hold <= 1'h0;
        repeat (40) if (rd[p] !== 1'h1) axi_read(NCPM_REG_FLAGS);
        chk(32'(rd[p]), 32'h1);
        chk(32'(rd[8 + p]), xp ? 32'(ne) : 32'(code != 16'h0));
        if (xp) chk(32'(rd[16 + p]), 32'(ee));
        axi_read(NCPM_REG_CODE0 | {3'h0, p, 2'h0});
        chk(rd, {16'h0, code});
        if (k inside {NCPM_K_RECV, NCPM_K_CMND, NCPM_K_EXPL, NCPM_K_GATR, NCPM_K_WRD}) begin
            axi_read(NCPM_REG_DATA0 | {3'h0, p, 2'h0});
            chk(rd, {16'h0, ~code});
        end
        tick();
        axi_read(NCPM_REG_FLAGS);
        chk(32'(rd[24 + p]), 32'h1);
        tick();
        axi_read(NCPM_REG_FLAGS);
        chk(32'(rd[24 + p]), 32'h0);
    endtask : do_req
    task automatic tally_and_finish;
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        axi_read(NCPM_REG_FLAGS);
        chk(rd, 32'h0000_00ff);
        do_req(NCPM_K_SEND, 4'h2, 16'h0, 16'h0, 1'h0, 1'h0, 1'h1);
        do_req(NCPM_K_RECV, 4'h5, 16'h0, 16'h0105);
        do_req(NCPM_K_CMND, 4'h0, 16'h0501);
        do_req(NCPM_K_CMND, 4'h1, NCPM_CMD_EXPLICIT, 16'h0201, 1'h1, 1'h1);
        do_req(NCPM_K_GATR, 4'h3, 16'h0, 16'h1234, 1'h0, 1'h1);
        do_req(NCPM_K_SATR, 4'h3);
        do_req(NCPM_K_WRD, 4'h4);
        do_req(NCPM_K_WWR, 4'h5);
        do_req(NCPM_K_EXPL, 4'h7);
        do_req(NCPM_K_RECV, 4'hf);
        axi_read(8'h80);
        chk(32'(rr), 32'(NCPM_RESP_DECERR));
        axi_write(8'h84, 32'hffff_ffff);
        chk(32'(rr), 32'(NCPM_RESP_DECERR));
        tally_and_finish();
    end
endmodule : ncpm_port_manager_tb
